// [shared/reset_seq_pkg.sv]
// Purpose: Shared constants and types for the reset source sequencer.
// Assumes: One system clock; the watchdog oscillator arrives as a plain pin level.
// Notes:   Every count and index lives here, and the values after reset of the counters, pins and outputs.
//
// Operation
// R1 - In run or halt mode, a power-on or brownout condition forces full system reset.
// R2 - In run or halt mode, watchdog time-out resets only when configured for reset.
// R3 - Reset pin low forces full system reset in every operating mode.
// R4 - Debugger control bit 0 set resets everything except the on-chip debugger.
// R5 - In stop mode only supply, reset pin and debug pin low cause reset.
// R6 - Supply above threshold enables power-on counter of 66 watchdog oscillator cycles.
// R7 - After that, a second counter counts 16 system clocks before it expires.
// R8 - System stays in reset until supply is good and both counters expire.
// R9 - Leaving power-on reset releases the core to fetch its reset vector.
// R10 - After power-on reset the power-on status flag reads as 1.
// R11 - Supply-good is a synchronized input; counters restart from zero when it drops.

package reset_seq_pkg;

    // Power-on counter: cycles of the watchdog oscillator before it expires.
    localparam int unsigned POR_OSC_CYCLES  = 66;
    localparam int unsigned POR_CNT_W       = 7;
    localparam logic [6:0]  POR_CNT_LAST    = 7'(POR_OSC_CYCLES - 1);
    localparam logic [6:0]  POR_CNT_RST     = 7'h00;

    // Clock settle counter: system clock pulses after the power-on counter.
    localparam int unsigned SETTLE_CLKS     = 16;
    localparam int unsigned SETTLE_CNT_W    = 5;
    localparam logic [4:0]  SETTLE_CNT_LAST = 5'(SETTLE_CLKS - 1);
    localparam logic [4:0]  SETTLE_CNT_RST  = 5'h00;

    // Bit positions of the pins that pass the synchroniser.
    localparam int unsigned SYNC_SUPPLY     = 0;
    localparam int unsigned SYNC_OSC        = 1;
    localparam int unsigned SYNC_PIN        = 2;
    localparam int unsigned SYNC_DBG        = 3;
    localparam int unsigned SYNC_W          = 4;
    // Idle levels: supply not yet good, oscillator low, both active-low pins high.
    localparam logic [3:0]  SYNC_RST_VAL    = 4'hC;

    // Operating mode reported by the power management logic.
    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10,
        MODE_RSVD = 2'b11
    } op_mode_e;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_SUPPLY_LOW = 2'b00,
        ST_POR_COUNT  = 2'b01,
        ST_SETTLE     = 2'b10,
        ST_RUN        = 2'b11
    } seq_state_e;

    // Requests and controls from logic on the system clock.
    typedef struct packed {
        logic wdt_timeout;       // Watchdog time-out event.
        logic wdt_reset_mode;    // Watchdog configured to reset, not interrupt.
        logic debugger_reset;    // Bit 0 of debugger_control_register.
        logic por_flag_clr;      // Software clears the power-on status flag.
    } reset_req_s;

    // Reset outputs, all from flip-flops.
    typedef struct packed {
        logic system_reset;      // Peripherals held in reset.
        logic core_reset;        // Processor core held in reset.
        logic debugger_reset;    // On-chip debugger held in reset.
        logic core_release;      // One-cycle pulse: core starts its reset vector fetch.
        logic por_status;        // Power-on status flag of watchdog_control_register.
    } reset_out_s;

    localparam reset_out_s RESET_OUT_RST = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

endpackage : reset_seq_pkg

// [logic/pin_sync.sv]
// Purpose: Two flip-flop synchroniser for a group of pins.
// Assumes: Each bit is an independent level; no bus coherence across bits.
// Notes:   The first stage is read only by the second stage.

`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int unsigned         W       = 1,
    parameter logic [W-1:0]        RST_VAL = '0
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [W-1:0]      pin_in,
    output var  logic [W-1:0]      pin_sync_out
);

    // One pair of flops per bit, each with its own idle value.
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic meta_d;
        logic stable_q;
        logic stable_d;

        always_comb begin
            meta_d   = pin_in[i];
            stable_d = meta_q;
        end

        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                meta_q   <= RST_VAL[i];
                stable_q <= RST_VAL[i];
            end else begin
                meta_q   <= meta_d;
                stable_q <= stable_d;
            end
        end

        assign pin_sync_out[i] = stable_q;
    end

endmodule : pin_sync

`default_nettype wire

// [logic/reset_source_sequencer.sv]
// Purpose: Gathers reset sources and sequences the power-on release of the core.
// Assumes: Supply-good, watchdog oscillator, reset pin and debug pin are asynchronous;
//          mode and requests come from logic on sys_clk.
// Notes:   The watchdog oscillator is sampled, so it must run well below sys_clk/2.

`timescale 1ns/1ps
`default_nettype none

module reset_source_sequencer (
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      supply_good,
    input  wire logic                      wdt_osc,
    input  wire logic                      reset_pin_n,
    input  wire logic                      debug_pin_n,
    input  wire reset_seq_pkg::op_mode_e   op_mode,
    input  wire reset_seq_pkg::reset_req_s req,
    output var  reset_seq_pkg::reset_out_s rst_out
);
    import reset_seq_pkg::*;

    logic [SYNC_W-1:0]        pins_raw;
    logic [SYNC_W-1:0]        pins_s;
    logic                     supply_ok;
    logic                     osc_s;
    logic                     pin_low;
    logic                     dbg_low;
    logic                     stop_mode;
    logic                     full_req;
    logic                     dbg_req;
    logic                     osc_rise;

    seq_state_e               state_q;
    seq_state_e               state_d;
    logic [POR_CNT_W-1:0]     por_cnt_q;
    logic [POR_CNT_W-1:0]     por_cnt_d;
    logic [SETTLE_CNT_W-1:0]  settle_cnt_q;
    logic [SETTLE_CNT_W-1:0]  settle_cnt_d;
    logic                     osc_prev_q;
    logic                     osc_prev_d;
    logic                     por_seq_q;
    logic                     por_seq_d;
    logic                     dbg_only_q;
    logic                     dbg_only_d;
    logic                     release_now;
    reset_out_s               out_q;
    reset_out_s               out_d;

    // All pins pass two flops before any decision looks at them.
    always_comb begin
        pins_raw              = '0;
        pins_raw[SYNC_SUPPLY] = supply_good;
        pins_raw[SYNC_OSC]    = wdt_osc;
        pins_raw[SYNC_PIN]    = reset_pin_n;
        pins_raw[SYNC_DBG]    = debug_pin_n;
    end

    pin_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST_VAL)
    ) u_pin_sync (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .pin_in       (pins_raw),
        .pin_sync_out (pins_s)
    );

    // Decoded levels after synchronisation.
    assign supply_ok = pins_s[SYNC_SUPPLY]; // R11
    assign osc_s     = pins_s[SYNC_OSC];
    assign pin_low   = ~pins_s[SYNC_PIN];
    assign dbg_low   = ~pins_s[SYNC_DBG];
    assign stop_mode = (op_mode == MODE_STOP);

    // Source selection by operating mode. The reset pin counts in every mode; the
    // debug pin only in stop, the watchdog and debugger only outside stop.
    always_comb begin
        full_req = pin_low; // R3
        dbg_req  = 1'b0;
        if (stop_mode) begin
            full_req = pin_low | dbg_low; // R5
        end else begin
            full_req = pin_low | (req.wdt_timeout & req.wdt_reset_mode); // R2
            dbg_req  = req.debugger_reset; // R4
        end
    end

    // Rising edge of the sampled watchdog oscillator advances the power-on counter.
    // The edge detector reads the second synchroniser stage, never the first.
    always_comb begin
        osc_prev_d = osc_s;
        osc_rise   = osc_s & ~osc_prev_q;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_prev_d;
        end
    end

    // Sequencer. A dropped supply always wins and throws both counters back to zero,
    // so a brownout mid-sequence restarts the whole power-on count.
    always_comb begin
        state_d      = state_q;
        por_cnt_d    = por_cnt_q;
        settle_cnt_d = settle_cnt_q;
        por_seq_d    = por_seq_q;
        dbg_only_d   = dbg_only_q;
        release_now  = 1'b0;
        if (!supply_ok) begin
            state_d      = ST_SUPPLY_LOW; // R1
            por_cnt_d    = POR_CNT_RST; // R11
            settle_cnt_d = SETTLE_CNT_RST; // R11
            por_seq_d    = 1'b1;
            dbg_only_d   = 1'b0;
        end else begin
            unique case (state_q)
                ST_SUPPLY_LOW: begin
                    state_d   = ST_POR_COUNT; // R6
                    por_cnt_d = POR_CNT_RST;
                end
                ST_POR_COUNT: begin
                    if (osc_rise) begin
                        if (por_cnt_q == POR_CNT_LAST) begin
                            state_d      = ST_SETTLE; // R7
                            settle_cnt_d = SETTLE_CNT_RST;
                        end else begin
                            por_cnt_d = por_cnt_q + 7'h01; // R6
                        end
                    end
                end
                ST_SETTLE: begin
                    if (full_req || dbg_req) begin
                        // A source still active holds the count at zero.
                        settle_cnt_d = SETTLE_CNT_RST;
                        dbg_only_d   = dbg_only_q & ~full_req;
                    end else if (settle_cnt_q == SETTLE_CNT_LAST) begin
                        state_d     = ST_RUN; // R8
                        release_now = 1'b1; // R9
                        por_seq_d   = 1'b0;
                        dbg_only_d  = 1'b0;
                    end else begin
                        settle_cnt_d = settle_cnt_q + 5'h01; // R7
                    end
                end
                ST_RUN: begin
                    if (full_req || dbg_req) begin
                        // Non power-on resets reuse the clock settle count as
                        // their minimum reset width.
                        state_d      = ST_SETTLE;
                        settle_cnt_d = SETTLE_CNT_RST;
                        dbg_only_d   = ~full_req; // R4
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q      <= ST_SUPPLY_LOW;
            por_cnt_q    <= POR_CNT_RST;
            settle_cnt_q <= SETTLE_CNT_RST;
            por_seq_q    <= 1'b1;
            dbg_only_q   <= 1'b0;
        end else begin
            state_q      <= state_d;
            por_cnt_q    <= por_cnt_d;
            settle_cnt_q <= settle_cnt_d;
            por_seq_q    <= por_seq_d;
            dbg_only_q   <= dbg_only_d;
        end
    end

    // Outputs are registered from the next state so they change with the state.
    // The status flag: being set on the power-on release wins over a software clear
    // in the same cycle, so the cause of reset is never lost.
    always_comb begin
        out_d                = out_q;
        out_d.system_reset   = (state_d != ST_RUN); // R8
        out_d.core_reset     = (state_d != ST_RUN); // R8
        out_d.debugger_reset = (state_d != ST_RUN) & ~dbg_only_d; // R4
        out_d.core_release   = release_now; // R9
        if (release_now && por_seq_q) begin
            out_d.por_status = 1'b1; // R10
        end else if (req.por_flag_clr) begin
            out_d.por_status = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_q <= RESET_OUT_RST;
        end else begin
            out_q <= out_d;
        end
    end

    assign rst_out = out_q;

endmodule : reset_source_sequencer

`default_nettype wire

// [sim/reset_seq_chk.sv]
// Purpose: Concurrent checks on the reset sequencer ports.
// Assumes: Pins pass a two-flop synchroniser before the logic sees them.
// Notes:   Pin conditions last three cycles so the synchroniser delay is covered.
`timescale 1ns/1ps
`default_nettype none
module reset_seq_chk (
    input wire logic                      sys_clk,
    input wire logic                      sys_rst,
    input wire logic                      supply_good,
    input wire logic                      reset_pin_n,
    input wire logic                      debug_pin_n,
    input wire reset_seq_pkg::op_mode_e   op_mode,
    input wire reset_seq_pkg::reset_req_s req,
    input wire reset_seq_pkg::reset_out_s rst_out
);
    import reset_seq_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Short aliases keep the properties on one line.
    wire logic srst = rst_out.system_reset;
    wire logic drst = rst_out.debugger_reset;

    a_core_tracks_sys: assert property (rst_out.core_reset == srst)
        else $error("core reset differs from system reset");
    a_release_one: assert property (rst_out.core_release |=> !rst_out.core_release)
        else $error("release pulse longer than one cycle");
    a_release_drop: assert property (rst_out.core_release |-> !srst && $past(srst))
        else $error("release pulse without reset falling");
    a_pin_full: assert property ((!reset_pin_n)[*3] |=> srst && drst)
        else $error("reset pin did not give a full reset");
    a_supply_low: assert property ((!supply_good)[*3] |=> srst)
        else $error("low supply did not hold reset");
    a_stop_dbg_pin: assert property ((!debug_pin_n && op_mode == MODE_STOP)[*3] |=> srst && drst)
        else $error("debug pin in stop did not give a full reset");
    a_wdt_full: assert property (!srst && req.wdt_timeout && req.wdt_reset_mode && op_mode != MODE_STOP
        |=> srst && drst)
        else $error("watchdog reset missing");
    a_dbg_only: assert property ((reset_pin_n && supply_good)[*3] ##0 (!srst && req.debugger_reset
        && !req.wdt_timeout && op_mode != MODE_STOP) |=> srst && !drst)
        else $error("debugger reset wrong");
    a_wdt_ignored: assert property ((reset_pin_n && debug_pin_n && supply_good)[*3] ##0
        (!srst && !req.wdt_reset_mode && !req.debugger_reset) |=> !srst)
        else $error("reset without a cause");
    a_min_width: assert property ($fell(srst) |-> $past(srst, 16))
        else $error("reset shorter than the settle count");
    a_flag_on_release: assert property ($rose(rst_out.por_status) |-> rst_out.core_release)
        else $error("status flag set outside release");

    c_por_release: cover property (rst_out.core_release && rst_out.por_status);
    c_dbg_only: cover property (srst && !drst);
    c_stop_reset: cover property (op_mode == MODE_STOP && srst && drst);
endmodule : reset_seq_chk

bind reset_source_sequencer reset_seq_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .supply_good(supply_good), .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n),
    .op_mode(op_mode), .req(req), .rst_out(rst_out));
`default_nettype wire

// [sim/core_model.sv]
// Purpose: Stand-in for the core and debugger that receive reset.
// Assumes: Resets and the release pulse are sampled on sys_clk.
// Notes:   It only counts; it never drives the sequencer.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic                      sys_clk,
    input  wire reset_seq_pkg::reset_out_s rst_in,
    output var  int                        fetch_cnt,
    output var  int                        dbg_cnt
);
    import reset_seq_pkg::*;
    int   f_q   = 0;
    int   d_q   = 0;
    logic dbg_q = 1'b1;
    // A fetch counts only with the core out of reset, so a release pulse while in reset is not counted.
    always @(posedge sys_clk) begin
        if (rst_in.core_release && !rst_in.core_reset) begin
            f_q <= f_q + 1;
        end
        if (rst_in.debugger_reset && !dbg_q) begin
            d_q <= d_q + 1;
        end
        dbg_q <= rst_in.debugger_reset;
    end
    assign fetch_cnt = f_q;
    assign dbg_cnt   = d_q;
endmodule : core_model
`default_nettype wire

// [sim/tb.sv]
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: Watchdog oscillator runs free at six system clocks a period.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import reset_seq_pkg::*;
    logic       sys_clk     = 1'b0;
    logic       sys_rst     = 1'b1;
    logic       supply_good = 1'b0;
    logic       wdt_osc     = 1'b0;
    logic       reset_pin_n = 1'b1;
    logic       debug_pin_n = 1'b1;
    op_mode_e   op_mode     = MODE_RUN;
    reset_req_s req         = '0;
    reset_out_s rst_out;
    int         fetch_cnt;
    int         dbg_cnt;
    int         error_cnt   = 0;
    int         cmp_count   = 0;
    int         exp_fetch   = 0;
    int         n;
    // Each oscillator phase spans three clocks, above the synchroniser minimum.
    always #20 sys_clk = ~sys_clk;
    always #120 wdt_osc = ~wdt_osc;
    reset_source_sequencer uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .supply_good(supply_good),
        .wdt_osc(wdt_osc), .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n),
        .op_mode(op_mode), .req(req), .rst_out(rst_out));
    core_model core (.sys_clk(sys_clk), .rst_in(rst_out), .fetch_cnt(fetch_cnt), .dbg_cnt(dbg_cnt));

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic check_bit(string what, logic exp, logic got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_int(string what, int exp, int got);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : check_int
    task automatic cycles(int k);
        repeat (k) @(negedge sys_clk);
    endtask : cycles
    // Bounded wait for the release pulse; n holds the cycles it took.
    task automatic wait_release;
        n = 0;
        while (rst_out.core_release !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        check_bit("core release", 1'b1, rst_out.core_release);
        check_bit("core reset", 1'b0, rst_out.core_reset);
        exp_fetch++;
        cycles(1);
        check_int("fetch count", exp_fetch, fetch_cnt);
    endtask : wait_release
    task automatic t_power_on;
        @(negedge sys_clk);
        supply_good = 1'b1;
        wait_release;
        check_bit("power-on delay", 1'b1, n >= 65 * 6 + 16 && n <= 66 * 6 + 28);
        check_bit("power-on status", 1'b1, rst_out.por_status);
        check_bit("debugger reset", 1'b0, rst_out.debugger_reset);
    endtask : t_power_on
    task automatic t_pin(op_mode_e m);
        op_mode = m;
        reset_pin_n = 1'b0;
        cycles(4);
        check_bit("pin system reset", 1'b1, rst_out.system_reset);
        check_bit("pin debugger reset", 1'b1, rst_out.debugger_reset);
        reset_pin_n = 1'b1;
        wait_release;
        check_bit("pin hold width", 1'b1, n >= 16 && n <= 22);
        check_bit("status kept", 1'b1, rst_out.por_status);
    endtask : t_pin
    task automatic t_wdt;
        req.wdt_timeout = 1'b1;
        cycles(1);
        req.wdt_timeout = 1'b0;
        cycles(3);
        check_bit("watchdog as interrupt", 1'b0, rst_out.system_reset);
        req.wdt_reset_mode = 1'b1;
        req.wdt_timeout = 1'b1;
        cycles(1);
        req.wdt_timeout = 1'b0;
        check_bit("watchdog system reset", 1'b1, rst_out.system_reset);
        check_bit("watchdog debugger reset", 1'b1, rst_out.debugger_reset);
        wait_release;
        req.wdt_reset_mode = 1'b0;
    endtask : t_wdt
    task automatic t_dbg;
        int d;
        d = dbg_cnt;
        op_mode = MODE_RSVD; // The reserved code must behave like run mode.
        req.debugger_reset = 1'b1;
        cycles(2);
        check_bit("debugger request system reset", 1'b1, rst_out.system_reset);
        check_bit("debugger kept", 1'b0, rst_out.debugger_reset);
        req.debugger_reset = 1'b0;
        wait_release;
        check_int("debugger reset count", d, dbg_cnt);
        op_mode = MODE_RUN;
    endtask : t_dbg
    task automatic t_stop;
        op_mode = MODE_STOP;
        req = 4'hE;
        cycles(3);
        check_bit("stop ignores requests", 1'b0, rst_out.system_reset);
        req = '0;
        debug_pin_n = 1'b0;
        cycles(4);
        check_bit("debug pin system reset", 1'b1, rst_out.system_reset);
        check_bit("debug pin debugger reset", 1'b1, rst_out.debugger_reset);
        debug_pin_n = 1'b1;
        wait_release;
        op_mode = MODE_HALT;
        debug_pin_n = 1'b0;
        cycles(4);
        check_bit("debug pin outside stop", 1'b0, rst_out.system_reset);
        debug_pin_n = 1'b1;
        op_mode = MODE_RUN;
    endtask : t_stop
    // A drop in mid-count must restart the power-on count from zero.
    task automatic t_supply;
        req.por_flag_clr = 1'b1;
        cycles(1);
        req.por_flag_clr = 1'b0;
        check_bit("status cleared", 1'b0, rst_out.por_status);
        supply_good = 1'b0;
        cycles(4);
        check_bit("brownout reset", 1'b1, rst_out.system_reset);
        supply_good = 1'b1;
        cycles(200);
        check_bit("held during count", 1'b1, rst_out.system_reset);
        supply_good = 1'b0;
        cycles(4);
        t_power_on;
    endtask : t_supply

    initial begin
        cycles(5);
        sys_rst = 1'b0;
        t_power_on;
        t_pin(MODE_RUN);
        t_pin(MODE_HALT);
        t_pin(MODE_STOP);
        op_mode = MODE_RUN;
        t_wdt;
        t_dbg;
        t_stop;
        t_supply;
        end_sim;
    end
    // Whole run needs about 1200 clocks; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        end_sim;
    end
endmodule : tb
`default_nettype wire
